// file: include/fbpsm_defines.svh
// Constants for the fieldbus process slot map
`ifndef FBPSM_DEFINES_SVH
`define FBPSM_DEFINES_SVH

// Slot layout
`define FBPSM_SLOT_FIRST  4'h1
`define FBPSM_SLOT_LAST   4'h8
`define FBPSM_CYC_WORDS   4'h9
`define FBPSM_LAST_WIDX   4'h8

// Word positions in the cyclic input image
`define FBPSM_W_STAT_HI   4'h0
`define FBPSM_W_STAT_LO   4'h1
`define FBPSM_W_VOLT      4'h2
`define FBPSM_W_CURR      4'h3
`define FBPSM_W_POWR      4'h4

// Source register numbers carried alongside each cyclic word
`define FBPSM_REG_STATUS  10'h1f9
`define FBPSM_REG_VOLT    10'h1fb
`define FBPSM_REG_CURR    10'h1fc
`define FBPSM_REG_POWR    10'h1fd
`define FBPSM_REG_NONE    10'h000

// Station address limit and current full-scale code
`define FBPSM_ADDR_MAX    7'h7d
`define FBPSM_CURR_FULL   16'hcccc

// Default acyclic answer timeout in clock cycles
`define FBPSM_TMO_DEF     64

`endif

// file: include/fbpsm_pkg.sv
// Types shared by the fieldbus process slot map
package fbpsm_pkg;

  typedef logic [15:0] fbpsm_word_t;

  typedef enum logic [2:0] {
    FBPSM_ST_IDLE = 3'b001,
    FBPSM_ST_CYC  = 3'b010,
    FBPSM_ST_ACYC = 3'b100
  } fbpsm_state_t;

endpackage

// file: rtl/fbpsm_sat.sv
// Full-scale saturation of an encoded actual value
`timescale 1ns/1ps
`include "fbpsm_defines.svh"

module fbpsm_sat (
  input  wire fbpsm_pkg::fbpsm_word_t code_in,
  output fbpsm_pkg::fbpsm_word_t      code_out,
  output logic                        over
);
  import fbpsm_pkg::*;

  // Codes above full scale have no meaning, so they are pinned to 100 percent
  always_comb begin
    over     = (code_in > `FBPSM_CURR_FULL);
    code_out = over ? fbpsm_word_t'(`FBPSM_CURR_FULL) : code_in;
  end

endmodule

// file: rtl/fbpsm_slot_map.sv
// Fieldbus process slot map: cyclic input image and acyclic slot windows
// How it works
// - Slot 1 carries the unit status word of register 505 in every cyclic exchange.
// - Slot 2 carries the actual voltage of register 507 cyclically.
// - Slot 3 carries the actual current of register 508 cyclically.
// - Slot 4 carries the actual power of register 509 cyclically.
// - Slots 5 to 8 carry no cyclic content and exist only for acyclic access.
// - Eight acyclic slots each own a set of indexes, read or written by slot and index.
// - Acyclic slots use only the input range, which serves both directions.
// - Set values and settable status are never sent cyclically, only acyclically.
// - The slave repeatedly delivers its process data to the master's input area.
// - Current codes 0 to 0xcccc map linearly to 0 to 100 percent of nominal.
// - The slave answers only its own station address, settable from 0 to 125.
`timescale 1ns/1ps
`include "fbpsm_defines.svh"

module fbpsm_slot_map #(
  parameter int IDX_W      = 8,
  parameter int TMO_CYCLES = `FBPSM_TMO_DEF
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [6:0]             stn_addr,
  input  wire logic [6:0]             bus_addr,
  input  wire logic [31:0]            unit_status,
  input  wire fbpsm_pkg::fbpsm_word_t act_volt,
  input  wire fbpsm_pkg::fbpsm_word_t act_curr,
  input  wire fbpsm_pkg::fbpsm_word_t act_powr,
  input  wire logic                   cyc_req,
  input  wire logic                   acyc_req,
  input  wire logic                   acyc_wr,
  input  wire logic [3:0]             acyc_slot,
  input  wire logic [IDX_W-1:0]       acyc_index,
  input  wire fbpsm_pkg::fbpsm_word_t acyc_wdata,
  input  wire logic                   unit_ack,
  input  wire fbpsm_pkg::fbpsm_word_t unit_rdata,
  output logic                        busy_r,
  output logic                        cyc_word_valid_r,
  output logic [3:0]                  cyc_word_idx_r,
  output fbpsm_pkg::fbpsm_word_t      cyc_word_r,
  output logic [9:0]                  cyc_word_reg_r,
  output logic                        cyc_last_r,
  output logic                        curr_over_r,
  output logic                        unit_req_r,
  output logic                        unit_wr_r,
  output logic [3:0]                  unit_slot_r,
  output logic [IDX_W-1:0]            unit_index_r,
  output fbpsm_pkg::fbpsm_word_t      unit_wdata_r,
  output logic                        acyc_done_r,
  output logic                        acyc_err_r,
  output fbpsm_pkg::fbpsm_word_t      acyc_rdata_r
);
  import fbpsm_pkg::*;

  localparam int TMO_W = $clog2(TMO_CYCLES + 1);

  // Refuse sizes the counter or the index field cannot serve
  if (TMO_CYCLES < 1 || TMO_CYCLES > 1000 || IDX_W < 1 || IDX_W > 16) begin : g_chk
    $error("fbpsm_slot_map: TMO_CYCLES or IDX_W out of range");
  end

  fbpsm_state_t     state_r, state_nxt;
  logic [3:0]       widx_r, widx_nxt;
  logic [TMO_W-1:0] tmo_r, tmo_nxt;
  logic [31:0]      snap_stat_r, snap_stat_nxt;
  fbpsm_word_t      snap_volt_r, snap_volt_nxt;
  fbpsm_word_t      snap_curr_r, snap_curr_nxt;
  fbpsm_word_t      snap_powr_r, snap_powr_nxt;
  logic             busy_nxt, cvalid_nxt, clast_nxt, cover_nxt;
  logic [3:0]       cidx_nxt;
  fbpsm_word_t      cword_nxt;
  logic [9:0]       creg_nxt;
  logic             ureq_nxt, uwr_nxt, done_nxt, err_nxt;
  logic [3:0]       uslot_nxt;
  logic [IDX_W-1:0] uidx_nxt;
  fbpsm_word_t      uwdata_nxt, rdata_nxt;
  fbpsm_word_t      curr_sat;
  logic             curr_over;
  logic             addr_ok, acc_cyc, acc_acyc, slot_ok;

  // Current is saturated to its full-scale code before it enters the image
  fbpsm_sat u_curr_sat (
    .code_in  (act_curr),
    .code_out (curr_sat),
    .over     (curr_over)
  );

  // Station match; an address above the legal range never matches
  assign addr_ok  = (stn_addr <= `FBPSM_ADDR_MAX) && (bus_addr == stn_addr);
  // Cyclic exchange wins when both arrive in the same idle cycle
  assign acc_cyc  = (state_r == FBPSM_ST_IDLE) && cyc_req && addr_ok;
  assign acc_acyc = (state_r == FBPSM_ST_IDLE) && !cyc_req && acyc_req && addr_ok;
  assign slot_ok  = (acyc_slot >= `FBPSM_SLOT_FIRST) && (acyc_slot <= `FBPSM_SLOT_LAST);

  // Next-state logic for the sequencer, the cyclic image and the acyclic window
  always_comb begin
    state_nxt     = state_r;
    widx_nxt      = widx_r;
    tmo_nxt       = tmo_r;
    snap_stat_nxt = snap_stat_r;
    snap_volt_nxt = snap_volt_r;
    snap_curr_nxt = snap_curr_r;
    snap_powr_nxt = snap_powr_r;
    cover_nxt     = curr_over_r;
    cvalid_nxt    = 1'b0;
    clast_nxt     = 1'b0;
    cidx_nxt      = cyc_word_idx_r;
    cword_nxt     = cyc_word_r;
    creg_nxt      = cyc_word_reg_r;
    ureq_nxt      = 1'b0;
    uwr_nxt       = unit_wr_r;
    uslot_nxt     = unit_slot_r;
    uidx_nxt      = unit_index_r;
    uwdata_nxt    = unit_wdata_r;
    done_nxt      = 1'b0;
    err_nxt       = acyc_err_r;
    rdata_nxt     = acyc_rdata_r;
    unique case (state_r)
      FBPSM_ST_IDLE: begin
        if (acc_cyc) begin
          // Snapshot keeps all words of one exchange from the same instant
          snap_stat_nxt = unit_status;
          snap_volt_nxt = act_volt;
          snap_curr_nxt = curr_sat;
          snap_powr_nxt = act_powr;
          cover_nxt     = curr_over;
          widx_nxt      = 4'h0;
          state_nxt     = FBPSM_ST_CYC;
        end else if (acc_acyc) begin
          if (slot_ok) begin
            // Writes arrive on the same slot window as reads, no output range
            ureq_nxt   = 1'b1;
            uwr_nxt    = acyc_wr;
            uslot_nxt  = acyc_slot;
            uidx_nxt   = acyc_index;
            uwdata_nxt = acyc_wdata;
            tmo_nxt    = '0;
            state_nxt  = FBPSM_ST_ACYC;
          end else begin
            done_nxt  = 1'b1;
            err_nxt   = 1'b1;
            rdata_nxt = 16'h0000;
          end
        end
      end
      FBPSM_ST_CYC: begin
        // One word per cycle; only the status snapshot and actual values ever enter this image
        cvalid_nxt = 1'b1;
        cidx_nxt   = widx_r;
        clast_nxt  = (widx_r == `FBPSM_LAST_WIDX);
        case (widx_r)
          `FBPSM_W_STAT_HI: begin
            cword_nxt = snap_stat_r[31:16];
            creg_nxt  = `FBPSM_REG_STATUS;
          end
          `FBPSM_W_STAT_LO: begin
            cword_nxt = snap_stat_r[15:0];
            creg_nxt  = `FBPSM_REG_STATUS;
          end
          `FBPSM_W_VOLT: begin
            cword_nxt = snap_volt_r;
            creg_nxt  = `FBPSM_REG_VOLT;
          end
          `FBPSM_W_CURR: begin
            cword_nxt = snap_curr_r;
            creg_nxt  = `FBPSM_REG_CURR;
          end
          `FBPSM_W_POWR: begin
            cword_nxt = snap_powr_r;
            creg_nxt  = `FBPSM_REG_POWR;
          end
          default: begin
            cword_nxt = 16'h0000;
            creg_nxt  = `FBPSM_REG_NONE;
          end
        endcase
        if (widx_r == `FBPSM_LAST_WIDX) begin
          state_nxt = FBPSM_ST_IDLE;
        end else begin
          widx_nxt = widx_r + 4'h1;
        end
      end
      FBPSM_ST_ACYC: begin
        // A silent unit must not hang the slave, hence the timeout
        if (unit_ack) begin
          done_nxt  = 1'b1;
          err_nxt   = 1'b0;
          rdata_nxt = unit_wr_r ? 16'h0000 : unit_rdata;
          state_nxt = FBPSM_ST_IDLE;
        end else if (tmo_r == TMO_W'(TMO_CYCLES - 1)) begin
          done_nxt  = 1'b1;
          err_nxt   = 1'b1;
          rdata_nxt = 16'h0000;
          state_nxt = FBPSM_ST_IDLE;
        end else begin
          tmo_nxt = tmo_r + TMO_W'(1);
        end
      end
      default: begin
        state_nxt = FBPSM_ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != FBPSM_ST_IDLE);
  end

  // State and output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r          <= FBPSM_ST_IDLE;
      widx_r           <= 4'h0;
      tmo_r            <= '0;
      snap_stat_r      <= 32'h0000_0000;
      snap_volt_r      <= 16'h0000;
      snap_curr_r      <= 16'h0000;
      snap_powr_r      <= 16'h0000;
      busy_r           <= 1'b0;
      cyc_word_valid_r <= 1'b0;
      cyc_word_idx_r   <= 4'h0;
      cyc_word_r       <= 16'h0000;
      cyc_word_reg_r   <= 10'h000;
      cyc_last_r       <= 1'b0;
      curr_over_r      <= 1'b0;
      unit_req_r       <= 1'b0;
      unit_wr_r        <= 1'b0;
      unit_slot_r      <= 4'h0;
      unit_index_r     <= '0;
      unit_wdata_r     <= 16'h0000;
      acyc_done_r      <= 1'b0;
      acyc_err_r       <= 1'b0;
      acyc_rdata_r     <= 16'h0000;
    end else begin
      state_r          <= state_nxt;
      widx_r           <= widx_nxt;
      tmo_r            <= tmo_nxt;
      snap_stat_r      <= snap_stat_nxt;
      snap_volt_r      <= snap_volt_nxt;
      snap_curr_r      <= snap_curr_nxt;
      snap_powr_r      <= snap_powr_nxt;
      busy_r           <= busy_nxt;
      cyc_word_valid_r <= cvalid_nxt;
      cyc_word_idx_r   <= cidx_nxt;
      cyc_word_r       <= cword_nxt;
      cyc_word_reg_r   <= creg_nxt;
      cyc_last_r       <= clast_nxt;
      curr_over_r      <= cover_nxt;
      unit_req_r       <= ureq_nxt;
      unit_wr_r        <= uwr_nxt;
      unit_slot_r      <= uslot_nxt;
      unit_index_r     <= uidx_nxt;
      unit_wdata_r     <= uwdata_nxt;
      acyc_done_r      <= done_nxt;
      acyc_err_r       <= err_nxt;
      acyc_rdata_r     <= rdata_nxt;
    end
  end

  // Checks on the cyclic image and the acyclic window
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Nine valid words are split as eight plus one to keep the repetition small
  frame_nine_words_a: assert property (acc_cyc |=>
    ##1 cyc_word_valid_r [*8] ##1 cyc_word_valid_r ##1 !cyc_word_valid_r)
    else $error("cyclic frame is not nine consecutive words");
  status_word_a: assert property (cyc_word_valid_r && cyc_word_idx_r <= 4'h1 |->
    cyc_word_reg_r == 10'h1f9 &&
    cyc_word_r == (cyc_word_idx_r == 4'h0 ? snap_stat_r[31:16] : snap_stat_r[15:0]))
    else $error("slot 1 does not carry the status snapshot");
  volt_word_a: assert property (cyc_word_valid_r && cyc_word_idx_r == 4'h2 |->
    cyc_word_r == snap_volt_r && cyc_word_reg_r == 10'h1fb)
    else $error("slot 2 does not carry actual voltage");
  curr_word_a: assert property (cyc_word_valid_r && cyc_word_idx_r == 4'h3 |->
    cyc_word_r == snap_curr_r && cyc_word_r <= 16'hcccc && cyc_word_reg_r == 10'h1fc)
    else $error("slot 3 current word wrong or above full scale");
  powr_word_a: assert property (cyc_word_valid_r && cyc_word_idx_r == 4'h4 |->
    cyc_word_r == snap_powr_r && cyc_word_reg_r == 10'h1fd)
    else $error("slot 4 does not carry actual power");
  empty_slots_a: assert property (cyc_word_valid_r && cyc_word_idx_r >= 4'h5 |->
    cyc_word_r == 16'h0000 && cyc_word_reg_r == 10'h000)
    else $error("slots 5 to 8 carry cyclic content");
  foreign_addr_a: assert property (state_r == FBPSM_ST_IDLE && !addr_ok |=>
    state_r == FBPSM_ST_IDLE && !acyc_done_r && !unit_req_r)
    else $error("slave reacted to a foreign station address");
  bad_slot_a: assert property (acc_acyc && !slot_ok |=> acyc_done_r && acyc_err_r && !unit_req_r)
    else $error("out-of-range slot not refused");
  acyc_answer_a: assert property (unit_req_r |-> ##[1:TMO_CYCLES] acyc_done_r)
    else $error("acyclic access got no answer in time");

  frame_c:     cover property (acc_cyc ##10 cyc_last_r);
  acyc_rd_c:   cover property (unit_req_r && !unit_wr_r ##[1:16] unit_ack);
  acyc_wr_c:   cover property (unit_req_r && unit_wr_r ##[1:16] unit_ack);
  acyc_tmo_c:  cover property (acyc_done_r && acyc_err_r && state_r == FBPSM_ST_IDLE);

endmodule

// file: verif/fbpsm_unit_model.sv
// Register-side partner that answers forwarded acyclic accesses
`timescale 1ns/1ps
module fbpsm_unit_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [3:0]  slot,
  input  wire logic [7:0]  index,
  input  wire logic [15:0] wdata,
  input  wire logic [3:0]  dly,
  input  wire logic        mute,
  output logic             ack,
  output logic [15:0]      rdata
);
  logic [15:0] mem [0:4095];
  logic        seen [0:4095];
  logic        pend;
  logic [3:0]  cnt;
  logic [11:0] key;
  initial foreach (seen[i]) seen[i] = 1'b0;
  // Delay is chosen by the bench; mute drops an access so the block has to time out
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      pend <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata; // Data outside an answer never holds its last value
      if (req) begin
        pend <= 1'b1;
        cnt <= dly;
        key <= {slot, index};
        if (wr) begin
          mem[{slot, index}] <= wdata;
          seen[{slot, index}] <= 1'b1;
        end
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        ack <= !mute;
        rdata <= seen[key] ? mem[key] : {4'ha, key};
      end
    end
  end
endmodule

// file: verif/test_fbpsm_slot_map.sv
// Self-checking bench for the fieldbus process slot map
`timescale 1ns/1ps
module test_fbpsm_slot_map;
  import fbpsm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc_req = 1'b0, acyc_req = 1'b0, acyc_wr = 1'b0;
  logic [6:0] stn_addr = 7'h05, bus_addr = 7'h00;
  logic [31:0] unit_status = 32'h8001_4002;
  fbpsm_word_t act_volt = 16'h0, act_curr = 16'h0, act_powr = 16'h0, acyc_wdata = 16'h0;
  logic [3:0] acyc_slot = 4'h0, dly = 4'h0;
  logic [7:0] acyc_index = 8'h00;
  logic mute = 1'b0, unit_ack, busy_r, cyc_word_valid_r, cyc_last_r, curr_over_r, unit_req_r;
  logic unit_wr_r, acyc_done_r, acyc_err_r;
  fbpsm_word_t unit_rdata, cyc_word_r, unit_wdata_r, acyc_rdata_r;
  logic [3:0] cyc_word_idx_r, unit_slot_r;
  logic [9:0] cyc_word_reg_r;
  logic [7:0] unit_index_r;
  int fails = 0, checks = 0, fwds = 0, dones = 0, cycles = 0;
  always #10 clk = ~clk;
  fbpsm_slot_map #(.IDX_W(8), .TMO_CYCLES(8)) uut (.clk(clk), .rst(rst), .stn_addr(stn_addr),
    .bus_addr(bus_addr), .unit_status(unit_status), .act_volt(act_volt), .act_curr(act_curr),
    .act_powr(act_powr), .cyc_req(cyc_req), .acyc_req(acyc_req), .acyc_wr(acyc_wr),
    .acyc_slot(acyc_slot), .acyc_index(acyc_index), .acyc_wdata(acyc_wdata),
    .unit_ack(unit_ack), .unit_rdata(unit_rdata), .busy_r(busy_r),
    .cyc_word_valid_r(cyc_word_valid_r), .cyc_word_idx_r(cyc_word_idx_r),
    .cyc_word_r(cyc_word_r), .cyc_word_reg_r(cyc_word_reg_r), .cyc_last_r(cyc_last_r),
    .curr_over_r(curr_over_r), .unit_req_r(unit_req_r), .unit_wr_r(unit_wr_r),
    .unit_slot_r(unit_slot_r), .unit_index_r(unit_index_r), .unit_wdata_r(unit_wdata_r),
    .acyc_done_r(acyc_done_r), .acyc_err_r(acyc_err_r), .acyc_rdata_r(acyc_rdata_r));
  fbpsm_unit_model unit (.clk(clk), .rst(rst), .req(unit_req_r), .wr(unit_wr_r),
    .slot(unit_slot_r), .index(unit_index_r), .wdata(unit_wdata_r), .dly(dly), .mute(mute),
    .ack(unit_ack), .rdata(unit_rdata));
  // Count forwards and answers; a hang is cut short well past the expected run
  always @(posedge clk) begin
    fwds += (unit_req_r === 1'b1);
    dones += (acyc_done_r === 1'b1);
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One cyclic frame; with both set an acyclic request rides the same edge and must be lost
  task automatic cyc_frame(input fbpsm_word_t v, c, p, cexp, input logic oexp, both);
    fbpsm_word_t w [0:8];
    logic [9:0] r [0:8];
    int f0;
    int d0;
    w = '{unit_status[31:16], unit_status[15:0], v, cexp, p, 16'h0, 16'h0, 16'h0, 16'h0};
    r = '{10'h1f9, 10'h1f9, 10'h1fb, 10'h1fc, 10'h1fd, 10'h0, 10'h0, 10'h0, 10'h0};
    f0 = fwds;
    d0 = dones;
    @(posedge clk);
    {act_volt, act_curr, act_powr} <= {v, c, p};
    bus_addr <= stn_addr;
    cyc_req <= 1'b1;
    acyc_req <= both;
    acyc_slot <= 4'h2;
    @(posedge clk);
    cyc_req <= 1'b0;
    acyc_req <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      #1;
      chk("valid", cyc_word_valid_r, 1);
      chk("index", cyc_word_idx_r, i);
      chk("word", cyc_word_r, w[i]);
      chk("source", cyc_word_reg_r, r[i]);
      chk("last", cyc_last_r, i == 8);
      chk("busy", busy_r, i < 8);
      @(posedge clk);
    end
    #1;
    chk("idle", {cyc_word_valid_r, busy_r, curr_over_r}, {2'b00, oexp});
    chk("lost", {16'(fwds - f0), 16'(dones - d0)}, 0);
  endtask
  // A request to a station that is not ours, or to an illegal address, leaves all quiet
  task automatic cyc_refused(input logic [6:0] s, b);
    @(posedge clk);
    stn_addr <= s;
    bus_addr <= b;
    cyc_req <= 1'b1;
    @(posedge clk);
    cyc_req <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      chk("quiet", {busy_r, cyc_word_valid_r}, 0);
    end
  endtask
  // One acyclic access by slot and index, judged on its answer and on what was forwarded
  task automatic acyc(input logic w, input logic [3:0] s, input logic [7:0] x,
                      input fbpsm_word_t d, input logic e, input fbpsm_word_t q, input int f);
    int n;
    int f0;
    f0 = fwds;
    n = 0;
    @(posedge clk);
    bus_addr <= stn_addr;
    {acyc_req, acyc_wr, acyc_slot, acyc_index, acyc_wdata} <= {1'b1, w, s, x, d};
    @(posedge clk);
    acyc_req <= 1'b0;
    #1;
    while (acyc_done_r !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("answer", {acyc_done_r, acyc_err_r, acyc_rdata_r}, {1'b1, e, q});
    chk("forwards", fwds - f0, f);
    if (f != 0) begin
      chk("fwd fields", {unit_wr_r, unit_slot_r, unit_index_r}, {w, s, x});
      chk("fwd data", unit_wdata_r, d);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence: cyclic image, address filter, acyclic windows, timeout
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Current 0x0c0c is a scaled code the master turns back into amperes
    cyc_frame(16'h1234, 16'h0c0c, 16'h5678, 16'h0c0c, 1'b0, 1'b0);
    cyc_frame(16'hfedc, 16'hffff, 16'h0001, 16'hcccc, 1'b1, 1'b1);
    cyc_frame(16'h0000, 16'hcccc, 16'hffff, 16'hcccc, 1'b0, 1'b0);
    cyc_refused(7'h0a, 7'h0b);
    cyc_refused(7'h7e, 7'h7e);
    @(posedge clk);
    stn_addr <= 7'h7d;
    cyc_frame(16'h0101, 16'h0202, 16'h0303, 16'h0202, 1'b0, 1'b0);
    @(posedge clk);
    stn_addr <= 7'h00;
    for (int s = 1; s <= 8; s++) begin
      acyc(1'b0, s[3:0], 8'h07, 16'h0, 1'b0, {4'ha, s[3:0], 8'h07}, 1);
      acyc(1'b1, s[3:0], 8'h10 + s[7:0], {8'h5a, s[7:0]}, 1'b0, 16'h0, 1);
      acyc(1'b0, s[3:0], 8'h10 + s[7:0], 16'h0, 1'b0, {8'h5a, s[7:0]}, 1);
    end
    acyc(1'b0, 4'h0, 8'h01, 16'h0, 1'b1, 16'h0, 0);
    acyc(1'b1, 4'h9, 8'h01, 16'h1111, 1'b1, 16'h0, 0);
    acyc(1'b0, 4'hf, 8'h01, 16'h0, 1'b1, 16'h0, 0);
    @(posedge clk);
    dly <= 4'h5;
    acyc(1'b0, 4'h3, 8'h13, 16'h0, 1'b0, 16'h5a03, 1);
    @(posedge clk);
    mute <= 1'b1;
    acyc(1'b0, 4'h4, 8'h14, 16'h0, 1'b1, 16'h0, 1);
    wrap_up();
  end
endmodule
